// *** logic/hpi_pkg.sv ***
// Constants, register map and carrier types for the hub port power and indicator block.
// Assumes a single 125 MHz core clock and a classic Wishbone master with byte addresses.
package hpi_pkg;
    // Clock rate and the millisecond timebase derived from it.
    localparam int CLK_FREQ_KHZ = 125000;
    localparam int TIMEBASE_MS = 1;
    localparam int MS_CYCLES = CLK_FREQ_KHZ * TIMEBASE_MS;
    // Half period of the manual blink patterns, in milliseconds.
    localparam int BLINK_HALF_MS = 500;
    // Width of the free-running divider that makes the LED modulation square wave.
    localparam int MOD_DIV_BITS = 4;
    // Default overcurrent filter period, in milliseconds.
    localparam logic [3:0] OC_FILTER_DEFAULT_MS = 4'h8;

    // Register byte offsets.
    localparam logic [7:0] ADDR_CONFIG = 8'h00;
    localparam logic [7:0] ADDR_PWR_SET = 8'h04;
    localparam logic [7:0] ADDR_PWR_CLR = 8'h08;
    localparam logic [7:0] ADDR_OC_STATUS = 8'h0c;
    localparam logic [7:0] ADDR_IND_CTRL = 8'h10;
    localparam logic [7:0] ADDR_IND_STATUS = 8'h14;
    localparam logic [7:0] ADDR_BABBLE = 8'h18;

    // Field positions inside the status words and the indicator control word.
    localparam int OC_CHG_LSB = 8;
    localparam int OC_OFF_LSB = 16;
    localparam int IND_AMBER_LSB = 8;
    localparam int IND_HUBCHAR_BIT = 16;
    localparam int IND_SEL_STRIDE = 4;

    // Configuration image as loaded by the EEPROM loader.
    typedef struct packed {
        logic [3:0] ocMsDisabled;
        logic [3:0] ocMsEnabled;
        logic [1:0] spare;
        logic ledModulate;
        logic noIndicators;
        logic ledActiveHigh;
        logic ocActiveHigh;
        logic pwrActiveHigh;
        logic ganged;
    } hpi_cfg_t;

    localparam hpi_cfg_t CFG_RESET = '{ocMsDisabled: OC_FILTER_DEFAULT_MS,
        ocMsEnabled: OC_FILTER_DEFAULT_MS, default: 1'b0};

    // Indicator selector codes, one per port; zero selects automatic mode.
    typedef enum logic [2:0] {
        IND_AUTO = 3'h0,
        IND_AMBER = 3'h1,
        IND_GREEN = 3'h2,
        IND_OFF = 3'h3,
        IND_BLINK_GREEN = 3'h4,
        IND_BLINK_AMBER = 3'h5,
        IND_BLINK_GA = 3'h6
    } hpi_ind_sel_t;

    // Downstream port state as reported by the hub port state machine.
    typedef enum logic [3:0] {
        PS_POWERED_OFF, PS_DISCONNECTED, PS_DISABLED, PS_NOT_CONFIGURED,
        PS_RESETTING, PS_TESTING, PS_ENABLED, PS_TRANSMIT, PS_TRANSMIT_R,
        PS_SUSPENDED, PS_RESUMING, PS_SEND_EOR, PS_RESTART
    } hpi_port_state_t;

    // Wishbone request and response carriers.
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [7:0] adr;
        logic [31:0] dat;
    } hpi_wb_req_t;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } hpi_wb_rsp_t;
endpackage

// *** logic/hpi_port_ctrl.sv ***
// Downstream port power switching, overcurrent filtering and port indicator control.
// Assumes synchronous inputs from the hub logic and asynchronous sense pins from the switches.
//
// Overview of operation
// - Ganged or per-port switching, per-port by default.
// - Ports unpowered after reset until host powers them.
// - Power enable active level set by configuration.
// - Overcurrent accepted only after filter period, default 8ms.
// - Filter 0..15 ms, separate for enabled/disabled ports.
// - Accepted overcurrent is reported and removes port power.
// - Overcurrent sense active level set by configuration.
// - Indicator support bit advertised, cleared by configuration.
// - Each port drives a green and amber output.
// - Indicators start in automatic mode after reset.
// - Automatic: green when enabled, amber on overcurrent.
// - Automatic mode outputs are steady, never blinking.
// - Automatic colour follows the port state mapping.
// - Lit LEDs may be modulated by square wave.
// - LED output active level set by configuration.
// - Manual mode drives LEDs as host selects, except codes 6 (green/amber blink) and 7, which leave both dark.
// - Manual mode supports blinking patterns.
// - Manual codes: off, amber, green, blink patterns.
// - Babble latched in a status register; overcurrent lights amber in automatic mode.
// - Babble on an enabled port requests its disable.
`timescale 1ns/10ps
module hpi_port_ctrl #(
    parameter int NUM_PORTS = 4,
    parameter int MS_TICK_CYCLES = hpi_pkg::MS_CYCLES,
    parameter int BLINK_MS = hpi_pkg::BLINK_HALF_MS,
    parameter int MOD_BITS = hpi_pkg::MOD_DIV_BITS
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input hpi_pkg::hpi_wb_req_t wbReq,
    output hpi_pkg::hpi_wb_rsp_t wbRsp,
    input hpi_pkg::hpi_port_state_t portState [NUM_PORTS],
    input wire logic [NUM_PORTS-1:0] babbleDetect,
    output logic [NUM_PORTS-1:0] portDisableReq,
    input wire logic [NUM_PORTS-1:0] port_overcurrent_sense_n,
    output logic [NUM_PORTS-1:0] port_power_enable_n,
    output logic [NUM_PORTS-1:0] ledGreen,
    output logic [NUM_PORTS-1:0] ledAmber,
    output logic hubCharIndicators
);
    import hpi_pkg::*;

    localparam int MS_W = $clog2(MS_TICK_CYCLES + 1);
    localparam logic [MS_W-1:0] MS_LAST = MS_W'(MS_TICK_CYCLES - 1);
    localparam int BL_W = $clog2(BLINK_MS + 1);
    localparam logic [BL_W-1:0] BLINK_LAST = BL_W'(BLINK_MS - 1);
    localparam int SEL_W = IND_SEL_STRIDE * NUM_PORTS;

    hpi_cfg_t cfg_q;
    logic [MS_W-1:0] msCnt_q;
    logic msTick_q;
    logic [BL_W-1:0] blinkCnt_q;
    logic blinkPhase_q;
    logic [MOD_BITS-1:0] modCnt_q;
    logic modPhase;
    logic [NUM_PORTS-1:0] ocMeta_q;
    logic [NUM_PORTS-1:0] ocSync_q;
    logic [NUM_PORTS-1:0] ocAsserted;
    logic [NUM_PORTS-1:0] ocAccept;
    logic [NUM_PORTS-1:0] ocAcceptPrev_q;
    logic [NUM_PORTS-1:0] ocNew;
    logic [NUM_PORTS-1:0] ocHoldMask;
    logic [NUM_PORTS-1:0] ocTripMask;
    logic [NUM_PORTS-1:0] portEnabledVec;
    logic [NUM_PORTS-1:0] powerOn_q;
    logic [NUM_PORTS-1:0] powerOn_d;
    logic [NUM_PORTS-1:0] setMask;
    logic [NUM_PORTS-1:0] clrMask;
    logic [NUM_PORTS-1:0] ocOff_q;
    logic [NUM_PORTS-1:0] ocChange_q;
    logic [NUM_PORTS-1:0] babbleSeen_q;
    logic [NUM_PORTS-1:0] greenLit;
    logic [NUM_PORTS-1:0] amberLit;
    logic [SEL_W-1:0] indCtrl_q;
    logic ack_q;
    logic [31:0] rdData_q;
    logic [31:0] rdData_d;
    logic [31:0] byteMask;
    logic [31:0] wrBits;
    logic reqHit;
    logic writeNow;
    logic [NUM_PORTS-1:0] wrPort;

    // Bus qualifiers: a write lands on the edge at which the master sees ack high.
    assign reqHit = wbReq.cyc & wbReq.stb;
    assign writeNow = reqHit & wbReq.we & ack_q;
    assign byteMask = {{8{wbReq.sel[3]}}, {8{wbReq.sel[2]}}, {8{wbReq.sel[1]}},
                       {8{wbReq.sel[0]}}};
    assign wrBits = wbReq.dat & byteMask;
    assign wrPort = wrBits[NUM_PORTS-1:0];

    // One ack cycle per request; ack drops the cycle after it was given.
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            ack_q <= 1'b0;
            rdData_q <= 32'h0000_0000;
        end
        else
        begin
            ack_q <= reqHit & ~ack_q;
            if (reqHit & ~ack_q)
            begin
                rdData_q <= rdData_d;
            end
        end
    end

    assign wbRsp.ack = ack_q;
    assign wbRsp.dat = rdData_q;

    // Read decode; unmapped offsets still ack and read as zero so software never hangs.
    always_comb
    begin
        rdData_d = 32'h0000_0000;
        if (wbReq.adr == ADDR_CONFIG)
        begin
            rdData_d = 32'(cfg_q);
        end
        else if (wbReq.adr == ADDR_PWR_SET || wbReq.adr == ADDR_PWR_CLR)
        begin
            rdData_d = 32'(powerOn_q);
        end
        else if (wbReq.adr == ADDR_OC_STATUS)
        begin
            rdData_d = 32'(ocHoldMask) | (32'(ocChange_q) << OC_CHG_LSB)
                | (32'(ocOff_q) << OC_OFF_LSB);
        end
        else if (wbReq.adr == ADDR_IND_CTRL)
        begin
            rdData_d = 32'(indCtrl_q);
        end
        else if (wbReq.adr == ADDR_IND_STATUS)
        begin
            rdData_d = 32'(greenLit) | (32'(amberLit) << IND_AMBER_LSB)
                | (32'(hubCharIndicators) << IND_HUBCHAR_BIT);
        end
        else if (wbReq.adr == ADDR_BABBLE)
        begin
            rdData_d = 32'(babbleSeen_q);
        end
    end

    // Configuration image, written by the EEPROM loader through the bus.
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            cfg_q <= CFG_RESET;
        end
        else if (writeNow && wbReq.adr == ADDR_CONFIG)
        begin
            cfg_q <= hpi_cfg_t'((cfg_q & ~byteMask[15:0]) | wrBits[15:0]);
        end
    end

    // Indicator selectors; all zero after reset, which is automatic mode.
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            indCtrl_q <= '0;
        end
        else if (writeNow && wbReq.adr == ADDR_IND_CTRL)
        begin
            indCtrl_q <= (indCtrl_q & ~byteMask[SEL_W-1:0]) | wrBits[SEL_W-1:0];
        end
    end

    // Millisecond timebase shared by every filter and the blink generator.
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            msCnt_q <= '0;
            msTick_q <= 1'b0;
        end
        else if (msCnt_q == MS_LAST)
        begin
            msCnt_q <= '0;
            msTick_q <= 1'b1;
        end
        else
        begin
            msCnt_q <= msCnt_q + 1'b1;
            msTick_q <= 1'b0;
        end
    end

    // Blink phase for the manual patterns only; automatic mode never reads it.
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            blinkCnt_q <= '0;
            blinkPhase_q <= 1'b0;
        end
        else if (msTick_q)
        begin
            if (blinkCnt_q == BLINK_LAST)
            begin
                blinkCnt_q <= '0;
                blinkPhase_q <= ~blinkPhase_q;
            end
            else
            begin
                blinkCnt_q <= blinkCnt_q + 1'b1;
            end
        end
    end

    // Free-running divider; its top bit is a 50 percent square wave for LED modulation.
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            modCnt_q <= '0;
        end
        else
        begin
            modCnt_q <= modCnt_q + 1'b1;
        end
    end

    assign modPhase = modCnt_q[MOD_BITS-1];

    // Two-stage synchroniser for the sense pins; only the second stage feeds logic.
    // Both stages reset to the idle pin level, so no false fault follows reset.
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            ocMeta_q <= '1;
            ocSync_q <= '1;
        end
        else
        begin
            ocMeta_q <= port_overcurrent_sense_n;
            ocSync_q <= ocMeta_q;
        end
    end

    // Polarity applied after synchronising, so a polarity change cannot glitch the meta stage.
    assign ocAsserted = cfg_q.ocActiveHigh ? ocSync_q : ~ocSync_q;

    // Per-port filter and indicator colour.
    for (genvar i = 0; i < NUM_PORTS; i++)
    begin : gPort
        logic [3:0] ocCnt_q;
        logic [3:0] period;
        logic [2:0] sel;
        logic poweredOff;

        assign portEnabledVec[i] = (portState[i] == PS_ENABLED)
            || (portState[i] == PS_TRANSMIT) || (portState[i] == PS_TRANSMIT_R);
        assign period = portEnabledVec[i] ? cfg_q.ocMsEnabled : cfg_q.ocMsDisabled;
        assign sel = indCtrl_q[IND_SEL_STRIDE*i +: 3];
        assign poweredOff = (portState[i] == PS_POWERED_OFF) || ~powerOn_q[i];

        // The count saturates at 15 and restarts the moment the sense input goes inactive.
        always_ff @(posedge core_clk)
        begin
            if (sys_rst || ~ocAsserted[i])
            begin
                ocCnt_q <= 4'h0;
            end
            else if (msTick_q && ocCnt_q != 4'hf)
            begin
                ocCnt_q <= ocCnt_q + 4'h1;
            end
        end

        // A zero period accepts the condition as soon as it is seen after synchronising.
        assign ocAccept[i] = ocAsserted[i] && (ocCnt_q >= period);

        // Colour selection; only the manual codes consult the blink phase.
        always_comb
        begin
            greenLit[i] = 1'b0;
            amberLit[i] = 1'b0;
            case (sel)
                IND_AUTO:
                begin
                    if (ocAccept[i])
                    begin
                        amberLit[i] = 1'b1;
                    end
                    else if (poweredOff)
                    begin
                        amberLit[i] = ocOff_q[i];
                    end
                    else
                    begin
                        greenLit[i] = portEnabledVec[i];
                    end
                end
                IND_AMBER:
                begin
                    amberLit[i] = 1'b1;
                end
                IND_GREEN:
                begin
                    greenLit[i] = 1'b1;
                end
                IND_BLINK_GREEN:
                begin
                    greenLit[i] = blinkPhase_q;
                end
                IND_BLINK_AMBER:
                begin
                    amberLit[i] = blinkPhase_q;
                end
                default:
                begin
                    // Off, and the reserved green/amber code, leave both LEDs dark.
                    greenLit[i] = 1'b0;
                    amberLit[i] = 1'b0;
                end
            endcase
        end
    end

    // A new acceptance trips the port; in ganged mode it trips every port at once.
    assign ocNew = ocAccept & ~ocAcceptPrev_q;
    assign ocTripMask = cfg_q.ganged ? {NUM_PORTS{|ocNew}} : ocNew;
    assign ocHoldMask = cfg_q.ganged ? {NUM_PORTS{|ocAccept}} : ocAccept;

    // Power requests from the host; ganged mode treats any port bit as all ports.
    always_comb
    begin
        setMask = '0;
        clrMask = '0;
        if (writeNow && wbReq.adr == ADDR_PWR_SET)
        begin
            setMask = cfg_q.ganged ? {NUM_PORTS{|wrPort}} : wrPort;
        end
        if (writeNow && wbReq.adr == ADDR_PWR_CLR)
        begin
            clrMask = cfg_q.ganged ? {NUM_PORTS{|wrPort}} : wrPort;
        end
    end

    // An overcurrent still in force overrides a power-on request, so a fault cannot be re-armed.
    assign powerOn_d = (powerOn_q | setMask) & ~clrMask & ~ocHoldMask;

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            powerOn_q <= '0;
            ocAcceptPrev_q <= '0;
        end
        else
        begin
            powerOn_q <= powerOn_d;
            ocAcceptPrev_q <= ocAccept;
        end
    end

    // Sticky overcurrent flags; a trip in the same cycle as its clear wins.
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            ocChange_q <= '0;
            ocOff_q <= '0;
        end
        else
        begin
            if (writeNow && wbReq.adr == ADDR_OC_STATUS)
            begin
                ocChange_q <= (ocChange_q & ~wrBits[OC_CHG_LSB +: NUM_PORTS]) | ocTripMask;
            end
            else
            begin
                ocChange_q <= ocChange_q | ocTripMask;
            end
            ocOff_q <= (ocOff_q & ~(setMask & ~ocHoldMask))
                | (ocTripMask & (powerOn_q | setMask));
        end
    end

    // Babble bookkeeping and the disable request back to the port state machine.
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            babbleSeen_q <= '0;
            portDisableReq <= '0;
        end
        else
        begin
            portDisableReq <= babbleDetect & portEnabledVec;
            if (writeNow && wbReq.adr == ADDR_BABBLE)
            begin
                babbleSeen_q <= (babbleSeen_q & ~wrPort) | babbleDetect;
            end
            else
            begin
                babbleSeen_q <= babbleSeen_q | babbleDetect;
            end
        end
    end

    // Output pins are registered; reset levels match the reset polarity of the configuration.
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            port_power_enable_n <= {NUM_PORTS{1'b1}};
        end
        else
        begin
            port_power_enable_n <= powerOn_q ^ {NUM_PORTS{~cfg_q.pwrActiveHigh}};
        end
    end

    // LED drive: modulation chops lit LEDs only, and absent indicators stay dark.
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            ledGreen <= {NUM_PORTS{1'b1}};
            ledAmber <= {NUM_PORTS{1'b1}};
            hubCharIndicators <= 1'b1;
        end
        else
        begin
            ledGreen <= (greenLit & {NUM_PORTS{(~cfg_q.ledModulate | modPhase)
                & ~cfg_q.noIndicators}}) ^ {NUM_PORTS{~cfg_q.ledActiveHigh}};
            ledAmber <= (amberLit & {NUM_PORTS{(~cfg_q.ledModulate | modPhase)
                & ~cfg_q.noIndicators}}) ^ {NUM_PORTS{~cfg_q.ledActiveHigh}};
            hubCharIndicators <= ~cfg_q.noIndicators;
        end
    end
endmodule

// *** verification/hpi_port_ctrl_properties.sv ***
// Concurrent checks on the pins and register bus of the port controller.
// Assumes it is bound to every instance of the controller.
`timescale 1ns/10ps
module hpi_port_ctrl_properties #(
    parameter int NUM_PORTS = 4,
    parameter int MS_TICK_CYCLES = 8,
    parameter int BLINK_MS = 2,
    parameter int MOD_BITS = 2
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire hpi_pkg::hpi_wb_req_t wbReq,
    input wire hpi_pkg::hpi_wb_rsp_t wbRsp,
    input wire hpi_pkg::hpi_port_state_t portState [NUM_PORTS],
    input wire logic [NUM_PORTS-1:0] babbleDetect,
    input wire logic [NUM_PORTS-1:0] portDisableReq,
    input wire logic [NUM_PORTS-1:0] port_overcurrent_sense_n,
    input wire logic [NUM_PORTS-1:0] port_power_enable_n,
    input wire logic [NUM_PORTS-1:0] ledGreen,
    input wire logic [NUM_PORTS-1:0] ledAmber,
    input wire logic hubCharIndicators
);
    import hpi_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // A request still waiting for its answer, and the answer itself.
    sequence reqOpen;
        wbReq.cyc && wbReq.stb && !wbRsp.ack;
    endsequence
    sequence ackSeen;
        wbRsp.ack;
    endsequence
    bus_answer_a: assert property (reqOpen |=> ackSeen)
        else $error("request not answered next cycle");
    ack_pulse_a: assert property (ackSeen |=> !wbRsp.ack)
        else $error("ack longer than one cycle");
    idle_quiet_a: assert property (!wbReq.cyc |=> !wbRsp.ack)
        else $error("ack without request");
    unmapped_zero_a: assert property (ackSeen and !wbReq.we && wbReq.adr == 8'h1c
        |-> wbRsp.dat == 32'h0) else $error("unmapped read not zero");
    babble_drop_a: assert property (babbleDetect[0] && portState[0] == PS_ENABLED
        |=> portDisableReq[0]) else $error("babble did not disable port");
    babble_cause_a: assert property (portDisableReq[0] |-> $past(babbleDetect[0]))
        else $error("disable request without babble");
    power_by_host_a: assert property ($fell(port_power_enable_n[0])
        |-> $past(wbRsp.ack, 2)) else $error("power pin fell without host write");
    indicator_adv_a: assert property ($changed(hubCharIndicators)
        |-> $past(wbRsp.ack) || $past(wbRsp.ack, 2)) else $error("indicator bit moved alone");
    reset_dark_a: assert property ($fell(sys_rst) |-> &port_power_enable_n && &ledGreen
        && &ledAmber && hubCharIndicators) else $error("outputs not idle after reset");
endmodule

bind hpi_port_ctrl hpi_port_ctrl_properties #(.NUM_PORTS(NUM_PORTS),
    .MS_TICK_CYCLES(MS_TICK_CYCLES), .BLINK_MS(BLINK_MS), .MOD_BITS(MOD_BITS)) props (
    .core_clk(core_clk), .sys_rst(sys_rst), .wbReq(wbReq), .wbRsp(wbRsp),
    .portState(portState), .babbleDetect(babbleDetect), .portDisableReq(portDisableReq),
    .port_overcurrent_sense_n(port_overcurrent_sense_n),
    .port_power_enable_n(port_power_enable_n), .ledGreen(ledGreen), .ledAmber(ledAmber),
    .hubCharIndicators(hubCharIndicators));

// *** verification/hpi_switch_model.sv ***
// Behavioural model of the external power switches that raise the fault flags.
// Assumes the bench commands each fault and the flag polarity in force.
`timescale 1ns/10ps
module hpi_switch_model #(
    parameter int N = 4
) (
    input wire logic [N-1:0] fault,
    input wire logic senseHigh,
    output logic [N-1:0] senseN
);
    // The flag pin rests at its inactive level, so a wrong polarity reading trips a port.
    assign senseN = senseHigh ? fault : ~fault;
endmodule

// *** verification/tb_top.sv ***
// Self-checking bench for the port controller, driven through its Wishbone registers.
// Assumes the switch model drives the sense pins; counts are shortened by parameters.
`timescale 1ns/10ps
module tb_top;
    import hpi_pkg::*;
    localparam int NP = 4;
    localparam int TICK = 8;
    localparam int HALF = 2 * TICK;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    hpi_wb_req_t wbReq = '0;
    hpi_wb_rsp_t wbRsp;
    hpi_port_state_t portState [NP];
    logic [NP-1:0] babbleDetect = '0;
    logic [NP-1:0] fault = '0;
    logic senseHigh = 1'b0;
    logic [NP-1:0] portDisableReq, senseN, pwrN, ledGreen, ledAmber, e;
    logic hubChar, g, a;
    logic [31:0] rd;
    logic [3:0] manExp [1:7] = '{4'h2, 4'h1, 4'h3, 4'h9, 4'h6, 4'h3, 4'h3};
    int failures = 0;
    int num_checks = 0;
    int n;

    hpi_port_ctrl #(.NUM_PORTS(NP), .MS_TICK_CYCLES(TICK), .BLINK_MS(2), .MOD_BITS(2)) dut (
        .core_clk(core_clk), .sys_rst(sys_rst), .wbReq(wbReq), .wbRsp(wbRsp),
        .portState(portState), .babbleDetect(babbleDetect), .portDisableReq(portDisableReq),
        .port_overcurrent_sense_n(senseN), .port_power_enable_n(pwrN),
        .ledGreen(ledGreen), .ledAmber(ledAmber), .hubCharIndicators(hubChar));
    hpi_switch_model #(.N(NP)) sw (.fault(fault), .senseHigh(senseHigh), .senseN(senseN));

    // Free-running 125 MHz clock.
    initial
    begin
        forever #4 core_clk = ~core_clk;
    end

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_pins(input logic [NP-1:0] got, input logic [NP-1:0] exp);
        chk_reg({28'h0, got}, {28'h0, exp});
    endtask

    // One classic cycle; the request is held until ack is seen at a rising edge.
    // A lost answer is ended by the watchdog alone.
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: adr, dat: dat};
        @(posedge core_clk);
        while (wbRsp.ack !== 1'b1)
        begin
            @(posedge core_clk);
        end
        rd = wbRsp.dat;
        wbReq <= '0;
        @(posedge core_clk);
    endtask

    task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
        wb(1'b1, adr, dat);
    endtask

    task automatic rdchk(input logic [7:0] adr, input logic [31:0] exp);
        wb(1'b0, adr, 32'h0);
        chk_reg(rd, exp);
    endtask

    task automatic cyc(input int c);
        repeat (c) @(posedge core_clk);
    endtask

    task automatic done(input string name);
        $display("test %s done at %0t", name, $time);
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Watchdog: the whole sequence needs under a thousand cycles.
    initial
    begin
        cyc(20000);
        failures++;
        close_out();
    end

    // Main sequence.
    initial
    begin
        portState = '{PS_ENABLED, PS_DISCONNECTED, PS_SUSPENDED, PS_POWERED_OFF};
        cyc(10);
        sys_rst <= 1'b0;
        cyc(1);
        chk_pins(pwrN, 4'hf);
        chk_pins(ledGreen & ledAmber, 4'hf);
        rdchk(ADDR_CONFIG, 32'h00008800);
        rdchk(ADDR_IND_CTRL, 32'h0);
        rdchk(ADDR_IND_STATUS, 32'h00010000);
        rdchk(8'h1c, 32'h0);
        done("reset");
        wr(ADDR_PWR_SET, 32'h5);
        cyc(3);
        chk_pins(pwrN, 4'b1010);
        wr(ADDR_PWR_CLR, 32'h4);
        cyc(3);
        chk_pins(pwrN, 4'b1110);
        chk_pins(ledAmber, 4'hf);
        for (int s = 0; s <= 12; s++)
        begin
            portState[0] <= hpi_port_state_t'(s);
            cyc(3);
            e = hpi_port_state_t'(s) inside {PS_ENABLED, PS_TRANSMIT, PS_TRANSMIT_R} ? 4'he : 4'hf;
            repeat (HALF + 2)
            begin
                chk_pins(ledGreen, e);
                @(posedge core_clk);
            end
        end
        portState[0] <= PS_ENABLED;
        done("auto colours");
        wr(ADDR_CONFIG, 32'h00008200);
        repeat (2)
        begin
            fault[0] <= 1'b1;
            cyc(6);
            fault[0] <= 1'b0;
            cyc(2);
        end
        cyc(30);
        chk_pins(pwrN, 4'b1110);
        fault[0] <= 1'b1;
        cyc(6);
        chk_pins(pwrN, 4'b1110);
        cyc(20);
        chk_pins(pwrN, 4'hf);
        chk_pins(ledAmber, 4'b1110);
        chk_pins(ledGreen, 4'hf);
        rdchk(ADDR_OC_STATUS, 32'h00010101);
        wr(ADDR_PWR_SET, 32'h1);
        cyc(3);
        chk_pins(pwrN, 4'hf);
        fault[0] <= 1'b0;
        cyc(5);
        wr(ADDR_OC_STATUS, 32'h100);
        rdchk(ADDR_OC_STATUS, 32'h00010000);
        chk_pins(ledAmber, 4'b1110);
        wr(ADDR_PWR_SET, 32'h1);
        cyc(3);
        chk_pins(pwrN, 4'b1110);
        rdchk(ADDR_OC_STATUS, 32'h0);
        wr(ADDR_CONFIG, 32'h00000f00);
        fault <= 4'b0011;
        cyc(5);
        wb(1'b0, ADDR_OC_STATUS, 32'h0);
        chk_reg(rd & 32'hffff, 32'h0202);
        fault <= '0;
        cyc(5);
        wr(ADDR_OC_STATUS, 32'hff00);
        done("overcurrent");
        wr(ADDR_CONFIG, 32'h0000880e);
        senseHigh <= 1'b1;
        cyc(100);
        chk_pins(pwrN, 4'b0001);
        chk_pins(ledGreen | ledAmber, 4'b0001);
        wb(1'b0, ADDR_OC_STATUS, 32'h0);
        chk_reg(rd & 32'hff, 32'h0);
        wr(ADDR_CONFIG, 32'h00008800);
        senseHigh <= 1'b0;
        done("polarity");
        for (int c = 1; c <= 7; c++)
        begin
            wr(ADDR_IND_CTRL, 32'(c));
            cyc(2);
            g = ledGreen[0];
            a = ledAmber[0];
            cyc(HALF);
            chk_pins({g ^ ledGreen[0], a ^ ledAmber[0], g & ledGreen[0], a & ledAmber[0]},
                manExp[c]);
        end
        wr(ADDR_IND_CTRL, 32'h2);
        wr(ADDR_CONFIG, 32'h00008820);
        cyc(3);
        n = 0;
        repeat (8)
        begin
            @(posedge core_clk);
            n += int'(!ledGreen[0]);
        end
        chk_reg(32'(n), 32'h4);
        wr(ADDR_CONFIG, 32'h00008800);
        wr(ADDR_IND_CTRL, 32'h0);
        cyc(3);
        chk_pins(ledGreen, 4'b1110);
        done("manual");
        babbleDetect <= 4'b0011;
        @(posedge core_clk);
        babbleDetect <= '0;
        @(posedge core_clk);
        chk_pins(portDisableReq, 4'b0001);
        rdchk(ADDR_BABBLE, 32'h3);
        wr(ADDR_BABBLE, 32'h3);
        rdchk(ADDR_BABBLE, 32'h0);
        wr(ADDR_CONFIG, 32'h00008810);
        cyc(3);
        chk_pins({3'b0, hubChar}, 4'h0);
        done("babble and advert");
        wr(ADDR_CONFIG, 32'h00000001);
        wr(ADDR_PWR_CLR, 32'h1);
        cyc(3);
        chk_pins(pwrN, 4'hf);
        wr(ADDR_PWR_SET, 32'h8);
        cyc(3);
        chk_pins(pwrN, 4'h0);
        fault <= 4'b0100;
        cyc(8);
        chk_pins(pwrN, 4'hf);
        wb(1'b0, ADDR_OC_STATUS, 32'h0);
        chk_reg(rd & 32'hff, 32'hf);
        fault <= '0;
        done("ganged");
        close_out();
    end
endmodule
